// File: core/gpio_pkg.sv
// constants and types shared by the port 4 / port 5 i/o block
package gpio_pkg;
    localparam int unsigned IDX_W   = 16;
    localparam int unsigned ADDR_W  = 18;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned P4_W    = 4;
    localparam int unsigned P5_W    = 8;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_P5_FUNC   = 16'hffcc;
    localparam logic [15:0] IDX_P5_LATCH  = 16'hffd8;
    localparam logic [15:0] IDX_P5_PULLUP = 16'hffe2;
    localparam logic [15:0] IDX_P5_DIR    = 16'hffe8;
    localparam logic [15:0] IDX_P4_LATCH  = 16'hffd7;
    localparam logic [15:0] IDX_P4_DIR    = 16'hffe7;
    localparam logic [15:0] IDX_SER_CTRL  = 16'hfff0;
    localparam logic [15:0] IDX_PWR_MODE  = 16'hfff1;
    localparam logic [15:0] IDX_LCD_SEL   = 16'hfff2;

    // reset values
    localparam logic [7:0] P5_FUNC_RST   = 8'h00;
    localparam logic [7:0] P5_LATCH_RST  = 8'h00;
    localparam logic [7:0] P5_PULLUP_RST = 8'h00;
    localparam logic [7:0] P5_DIR_RST    = 8'h00;
    localparam logic [7:0] P4_LATCH_RST  = 8'hf8;
    localparam logic [7:0] P4_DIR_RST    = 8'hf8;
    localparam logic [7:0] SER_CTRL_RST  = 8'h00;
    localparam logic [3:0] LCD_SEL_RST   = 4'h0;
    localparam logic [7:0] WO_READ_VALUE = 8'hff;

    // serial control register fields
    localparam int unsigned SC_TX_EN   = 0;
    localparam int unsigned SC_RX_EN   = 1;
    localparam int unsigned SC_EXT_CLK = 2;
    localparam int unsigned SC_CLK_OUT = 3;
    localparam int unsigned SC_SYNC    = 4;
    localparam int unsigned SC_IRQ_SEL = 5;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        PM_ACTIVE, PM_SUBACTIVE, PM_SLEEP, PM_SUBSLEEP, PM_WATCH, PM_STANDBY
    } power_mode_t;
endpackage

// File: core/reg_access_if.sv
// register access carrier between bus slave and register file
`timescale 1ns/1ps
interface reg_access_if;
    logic        wr_en;
    logic [15:0] wr_idx;
    logic [7:0]  wr_data;
    logic [15:0] rd_idx;
    logic [7:0]  rd_data;
    logic        rd_hit;
    modport slave (output wr_en, wr_idx, wr_data, rd_idx, input rd_data, rd_hit);
    modport regs  (input wr_en, wr_idx, wr_data, rd_idx, output rd_data, rd_hit);
endinterface

// File: core/pin_sync.sv
// three-stage input synchroniser, output moves when stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
    logic [WIDTH-1:0] out_d;

    always_comb begin
        out_d = out_q;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                out_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end else begin
            s1_q  <= async_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign sync_out = out_q;
endmodule

// File: core/axil_slave.sv
// axi4-lite slave turning bus transfers into indexed byte register accesses
`timescale 1ns/1ps
module axil_slave
    import gpio_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              resetn,
    // write address and data
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // write response
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // read
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [DATA_W-1:0]      rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // register side
    reg_access_if.slave            regs
);
    logic              aw_held_q, aw_held_d, w_held_q, w_held_d;
    logic [IDX_W-1:0]  aw_idx_q, aw_idx_d;
    logic [7:0]        w_byte_q, w_byte_d;
    logic              w_lane_q, w_lane_d;
    logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic              do_write, take_read;
    logic              awready_q, wready_q, arready_q;

    assign do_write   = aw_held_q && w_held_q && !bvalid_q;
    assign take_read  = arvalid && !rvalid_q;
    assign regs.wr_en   = do_write && w_lane_q;
    assign regs.wr_idx  = aw_idx_q;
    assign regs.wr_data = w_byte_q;
    assign regs.rd_idx  = araddr[ADDR_W-1:2];

    always_comb begin
        aw_held_d = aw_held_q;
        aw_idx_d  = aw_idx_q;
        w_held_d  = w_held_q;
        w_byte_d  = w_byte_q;
        w_lane_d  = w_lane_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        if (awvalid && !aw_held_q) begin
            aw_held_d = 1'b1;
            aw_idx_d  = awaddr[ADDR_W-1:2];
        end
        if (wvalid && !w_held_q) begin
            w_held_d = 1'b1;
            w_byte_d = wdata[7:0];
            w_lane_d = wstrb[0];
        end
        if (do_write) begin
            // write lookup uses its own decoder on the write port, not the read port
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = RESP_OKAY;
        end
        if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        if (take_read) begin
            rvalid_d = 1'b1;
            rresp_d  = regs.rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_d  = {24'h000000, regs.rd_data};
        end else if (rvalid_q && rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            aw_held_q <= 1'b0;
            aw_idx_q  <= '0;
            w_held_q  <= 1'b0;
            w_byte_q  <= 8'h00;
            w_lane_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            rvalid_q  <= 1'b0;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= '0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            arready_q <= 1'b1;
        end else begin
            aw_held_q <= aw_held_d;
            aw_idx_q  <= aw_idx_d;
            w_held_q  <= w_held_d;
            w_byte_q  <= w_byte_d;
            w_lane_q  <= w_lane_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
            // ready flags kept in flops so every bus output leaves a register
            awready_q <= !aw_held_d;
            wready_q  <= !w_held_d;
            arready_q <= !rvalid_d;
        end
    end

    assign awready = awready_q;
    assign wready  = wready_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign arready = arready_q;
    assign rvalid  = rvalid_q;
    assign rresp   = rresp_q;
    assign rdata   = rdata_q;
endmodule

// File: core/port45_io.sv
// port 4 and port 5 general-purpose i/o with serial and interrupt pin sharing
// What this block does
// - with transmit enabled, port 4 pin 2 carries serial transmit data whatever its direction.
// - with receive enabled, port 4 pin 1 feeds serial receive whatever its direction.
// - pin 0 is clock input on external clock, clock output on clock-out or sync mode, else i/o.
// - port 4 pins float in reset and standby, hold in sleep modes, work in active modes.
// - a port 5 data read returns the latch for every bit set as output.
// - a port 5 data read returns the live pin for every bit set as input.
// - the port 5 output latch clears to zero on reset.
// - a port 5 direction bit of one makes the pin an output, zero an input.
// - port 5 direction and data drive only pins left as general i/o by mode and lcd select.
// - all port 5 direction bits clear to zero on reset.
// - the port 5 direction register is write-only and reads back all ones.
// - a port 4 direction bit of one makes a general i/o pin an output, zero an input.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
module port45_io
    import gpio_pkg::*;
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              resetn,
    // axi4-lite register bus
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [DATA_W-1:0]      rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // port 4 pins
    input  wire logic [P4_W-1:0]   p4_pin_in,
    output logic      [P4_W-1:0]   p4_pin_out,
    output logic      [P4_W-1:0]   p4_pin_oe,
    // port 5 pins
    input  wire logic [P5_W-1:0]   p5_pin_in,
    output logic      [P5_W-1:0]   p5_pin_out,
    output logic      [P5_W-1:0]   p5_pin_oe,
    output logic      [P5_W-1:0]   p5_pullup_en,
    // on-chip serial interface and interrupt controller
    input  wire logic              ser_txd,
    input  wire logic              ser_sck_out,
    output logic                   ser_rxd,
    output logic                   ser_sck_in,
    output logic                   ext_irq_zero_n
);
    import gpio_pkg::*;

    reg_access_if bus ();
    logic [P4_W-1:0] p4_in;
    logic [P5_W-1:0] p5_in;

    axil_slave u_bus (
        .clock   (clock),
        .resetn  (resetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .regs    (bus.slave)
    );

    pin_sync #(.WIDTH(P4_W)) u_sync4 (
        .clock    (clock),
        .resetn   (resetn),
        .async_in (p4_pin_in),
        .sync_out (p4_in)
    );

    pin_sync #(.WIDTH(P5_W)) u_sync5 (
        .clock    (clock),
        .resetn   (resetn),
        .async_in (p5_pin_in),
        .sync_out (p5_in)
    );

    // software-visible state
    logic [7:0]  p5_func_q, p5_func_d, p5_latch_q, p5_latch_d;
    logic [7:0]  p5_pullup_q, p5_pullup_d, p5_dir_q, p5_dir_d;
    logic [7:0]  p4_latch_q, p4_latch_d, p4_dir_q, p4_dir_d;
    logic [7:0]  ser_ctrl_q, ser_ctrl_d;
    logic [3:0]  lcd_sel_q, lcd_sel_d;
    power_mode_t pwr_q, pwr_d;

    // illegal mode codes fall back to active rather than freezing the pins
    function automatic power_mode_t mode_of(input logic [2:0] code);
        case (code)
            3'h1:    mode_of = PM_SUBACTIVE;
            3'h2:    mode_of = PM_SLEEP;
            3'h3:    mode_of = PM_SUBSLEEP;
            3'h4:    mode_of = PM_WATCH;
            3'h5:    mode_of = PM_STANDBY;
            default: mode_of = PM_ACTIVE;
        endcase
    endfunction

    always_comb begin
        p5_func_d   = p5_func_q;
        p5_latch_d  = p5_latch_q;
        p5_pullup_d = p5_pullup_q;
        p5_dir_d    = p5_dir_q;
        p4_latch_d  = p4_latch_q;
        p4_dir_d    = p4_dir_q;
        ser_ctrl_d  = ser_ctrl_q;
        lcd_sel_d   = lcd_sel_q;
        pwr_d       = pwr_q;
        if (bus.wr_en) begin
            case (bus.wr_idx)
                IDX_P5_FUNC:   p5_func_d   = bus.wr_data;
                IDX_P5_LATCH:  p5_latch_d  = bus.wr_data;
                IDX_P5_PULLUP: p5_pullup_d = bus.wr_data;
                IDX_P5_DIR:    p5_dir_d    = bus.wr_data;
                IDX_P4_LATCH:  p4_latch_d  = {P4_LATCH_RST[7:3], bus.wr_data[2:0]};
                IDX_P4_DIR:    p4_dir_d    = {P4_DIR_RST[7:3], bus.wr_data[2:0]};
                IDX_SER_CTRL:  ser_ctrl_d  = {2'b00, bus.wr_data[5:0]};
                IDX_PWR_MODE:  pwr_d       = mode_of(bus.wr_data[2:0]);
                IDX_LCD_SEL:   lcd_sel_d   = bus.wr_data[3:0];
                default:       ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            p5_func_q   <= P5_FUNC_RST;
            p5_latch_q  <= P5_LATCH_RST;
            p5_pullup_q <= P5_PULLUP_RST;
            p5_dir_q    <= P5_DIR_RST;
            p4_latch_q  <= P4_LATCH_RST;
            p4_dir_q    <= P4_DIR_RST;
            ser_ctrl_q  <= SER_CTRL_RST;
            lcd_sel_q   <= LCD_SEL_RST;
            pwr_q       <= PM_ACTIVE;
        end else begin
            p5_func_q   <= p5_func_d;
            p5_latch_q  <= p5_latch_d;
            p5_pullup_q <= p5_pullup_d;
            p5_dir_q    <= p5_dir_d;
            p4_latch_q  <= p4_latch_d;
            p4_dir_q    <= p4_dir_d;
            ser_ctrl_q  <= ser_ctrl_d;
            lcd_sel_q   <= lcd_sel_d;
            pwr_q       <= pwr_d;
        end
    end

    // read side
    logic [7:0] p5_view, p4_view;
    assign p5_view = (p5_dir_q & p5_latch_q) | (~p5_dir_q & p5_in);
    assign p4_view = {4'hf, p4_in[3], (p4_dir_q[2:0] & p4_latch_q[2:0])
                      | (~p4_dir_q[2:0] & p4_in[2:0])};

    always_comb begin
        bus.rd_hit  = 1'b1;
        bus.rd_data = 8'h00;
        case (bus.rd_idx)
            IDX_P5_FUNC:   bus.rd_data = p5_func_q;
            IDX_P5_LATCH:  bus.rd_data = p5_view;
            IDX_P5_PULLUP: bus.rd_data = p5_pullup_q;
            IDX_P5_DIR:    bus.rd_data = WO_READ_VALUE;
            IDX_P4_LATCH:  bus.rd_data = p4_view;
            IDX_P4_DIR:    bus.rd_data = WO_READ_VALUE;
            IDX_SER_CTRL:  bus.rd_data = ser_ctrl_q;
            IDX_PWR_MODE:  bus.rd_data = {5'h00, pwr_q};
            IDX_LCD_SEL:   bus.rd_data = {4'h0, lcd_sel_q};
            default:       bus.rd_hit  = 1'b0;
        endcase
    end

    // pin function selection
    logic tx_en, rx_en, ext_clk, clk_out, sync_mode, irq_sel;
    assign tx_en     = ser_ctrl_q[SC_TX_EN];
    assign rx_en     = ser_ctrl_q[SC_RX_EN];
    assign ext_clk   = ser_ctrl_q[SC_EXT_CLK];
    assign clk_out   = ser_ctrl_q[SC_CLK_OUT];
    assign sync_mode = ser_ctrl_q[SC_SYNC];
    assign irq_sel   = ser_ctrl_q[SC_IRQ_SEL];

    logic [P4_W-1:0] p4_out_q, p4_out_d, p4_oe_q, p4_oe_d, f4_out, f4_oe;
    logic [P5_W-1:0] p5_out_q, p5_out_d, p5_oe_q, p5_oe_d, p5_pu_q, p5_pu_d;
    logic [P5_W-1:0] p5_general, p5_seg;
    logic            rxd_q, rxd_d, sck_in_q, sck_in_d, irq_q, irq_d;
    logic            frozen, floating;

    // upper segment group needs select bit 3, lower group bits 3 and 0
    assign p5_seg     = {{4{lcd_sel_q[3]}}, {4{lcd_sel_q[3] & lcd_sel_q[0]}}};
    assign p5_general = ~p5_func_q & ~p5_seg;
    assign frozen     = (pwr_q == PM_SLEEP) || (pwr_q == PM_SUBSLEEP) || (pwr_q == PM_WATCH);
    assign floating   = (pwr_q == PM_STANDBY);

    always_comb begin
        f4_out = {1'b0, p4_latch_q[2:0]};
        f4_oe  = {1'b0, p4_dir_q[2:0]};
        if (tx_en) begin
            f4_out[2] = ser_txd;
            f4_oe[2]  = 1'b1;
        end
        if (rx_en) begin
            f4_oe[1] = 1'b0;
        end
        if (ext_clk) begin
            f4_oe[0] = 1'b0;
        end else if (clk_out || sync_mode) begin
            f4_out[0] = ser_sck_out;
            f4_oe[0]  = 1'b1;
        end
        p4_out_d = f4_out;
        p4_oe_d  = f4_oe;
        p5_out_d = p5_latch_q;
        p5_oe_d  = p5_general & p5_dir_q;
        p5_pu_d  = ~p5_dir_q & p5_pullup_q;
        // sleep-class modes hold pins, standby floats them
        if (frozen) begin
            p4_out_d = p4_out_q;
            p4_oe_d  = p4_oe_q;
            p5_out_d = p5_out_q;
            p5_oe_d  = p5_oe_q;
        end else if (floating) begin
            p4_oe_d = '0;
            p5_oe_d = '0;
        end
        // idle levels keep the serial receiver and interrupt line quiet when unrouted
        rxd_d    = rx_en ? p4_in[1] : 1'b1;
        sck_in_d = ext_clk ? p4_in[0] : 1'b0;
        irq_d    = irq_sel ? p4_in[3] : 1'b1;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            p4_out_q <= '0;
            p4_oe_q  <= '0;
            p5_out_q <= '0;
            p5_oe_q  <= '0;
            p5_pu_q  <= '0;
            rxd_q    <= 1'b1;
            sck_in_q <= 1'b0;
            irq_q    <= 1'b1;
        end else begin
            p4_out_q <= p4_out_d;
            p4_oe_q  <= p4_oe_d;
            p5_out_q <= p5_out_d;
            p5_oe_q  <= p5_oe_d;
            p5_pu_q  <= p5_pu_d;
            rxd_q    <= rxd_d;
            sck_in_q <= sck_in_d;
            irq_q    <= irq_d;
        end
    end

    assign p4_pin_out     = p4_out_q;
    assign p4_pin_oe      = p4_oe_q;
    assign p5_pin_out     = p5_out_q;
    assign p5_pin_oe      = p5_oe_q;
    assign p5_pullup_en   = p5_pu_q;
    assign ser_rxd        = rxd_q;
    assign ser_sck_in     = sck_in_q;
    assign ext_irq_zero_n = irq_q;

    // checks
    logic run;
    assign run = (pwr_q == PM_ACTIVE) || (pwr_q == PM_SUBACTIVE);

    sequence s_read_of(logic [15:0] idx);
        arvalid && arready && (araddr[ADDR_W-1:2] == idx);
    endsequence

    a_tx_drive: assert property (@(posedge clock) disable iff (!resetn)
        run && tx_en |=> p4_pin_oe[2] && (p4_pin_out[2] == $past(ser_txd)))
        else $error("transmit pin not driven by serial data");
    a_rx_input: assert property (@(posedge clock) disable iff (!resetn)
        run && rx_en |=> !p4_pin_oe[1] && (ser_rxd == $past(p4_in[1])))
        else $error("receive pin driven or not forwarded");
    a_sck_modes: assert property (@(posedge clock) disable iff (!resetn)
        run && !ext_clk && (clk_out || sync_mode) |=> p4_pin_oe[0])
        else $error("serial clock output not driven");
    a_sck_input: assert property (@(posedge clock) disable iff (!resetn)
        run && ext_clk |=> !p4_pin_oe[0])
        else $error("serial clock input pin driven");
    a_irq_pin_in: assert property (@(posedge clock) disable iff (!resetn)
        1'b1 |=> !p4_pin_oe[3]
            && (ext_irq_zero_n == ($past(irq_sel) ? $past(p4_in[3]) : 1'b1)))
        else $error("interrupt pin misrouted");
    a_standby_float: assert property (@(posedge clock) disable iff (!resetn)
        floating |=> (p4_pin_oe == '0) && (p5_pin_oe == '0))
        else $error("pins driven in standby");
    a_sleep_hold: assert property (@(posedge clock) disable iff (!resetn)
        frozen [*2] |-> $stable(p4_pin_oe) && $stable(p4_pin_out))
        else $error("pins changed while held");
    a_p5_read_mix: assert property (@(posedge clock) disable iff (!resetn)
        s_read_of(IDX_P5_LATCH) |=> rdata[7:0] == $past(p5_view) && rresp == RESP_OKAY)
        else $error("port 5 read value wrong");
    a_dir_reads_ones: assert property (@(posedge clock) disable iff (!resetn)
        s_read_of(IDX_P5_DIR) |=> rvalid && (rdata[7:0] == 8'hff))
        else $error("direction register read not all ones");
    a_p5_oe_gate: assert property (@(posedge clock) disable iff (!resetn)
        run |=> p5_pin_oe == $past(p5_dir_q & ~p5_func_q & ~p5_seg))
        else $error("port 5 enable not gated by function");
    a_reset_clear: assert property (@(posedge clock)
        !resetn |=> (p5_latch_q == 8'h00) && (p5_dir_q == 8'h00) && (p4_pin_oe == '0))
        else $error("reset values wrong");
endmodule

// File: dv/pin_model.sv
// outside world at the port pads: resolves each pad from all drivers
`timescale 1ns/1ps
module pin_model (
    // port 4 pads
    input  wire logic [gpio_pkg::P4_W-1:0] p4_out,
    input  wire logic [gpio_pkg::P4_W-1:0] p4_oe,
    input  wire logic [gpio_pkg::P4_W-1:0] p4_ext,
    output logic      [gpio_pkg::P4_W-1:0] p4_lvl,
    // port 5 pads
    input  wire logic [gpio_pkg::P5_W-1:0] p5_out,
    input  wire logic [gpio_pkg::P5_W-1:0] p5_oe,
    input  wire logic [gpio_pkg::P5_W-1:0] p5_pu,
    input  wire logic [gpio_pkg::P5_W-1:0] p5_ext,
    output logic      [gpio_pkg::P5_W-1:0] p5_lvl
);
    import gpio_pkg::*;
    // an enabled pull-up wins over the outside source on an undriven pad
    assign p4_lvl = (p4_oe & p4_out) | (~p4_oe & p4_ext);
    assign p5_lvl = (p5_oe & p5_out) | (~p5_oe & (p5_pu | p5_ext));
endmodule

// File: dv/test_port45_io.sv
// self-checking bench for the port 4 / port 5 i/o block
`timescale 1ns/1ps
module test_port45_io;
    import gpio_pkg::*;
    logic              clock = 1'h0;
    logic              resetn = 1'h0;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic              awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic              arvalid = 1'h0, rready = 1'h0;
    logic [DATA_W-1:0] wdata = '0;
    logic [3:0]        wstrb = 4'hf;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp;
    logic [DATA_W-1:0] rdata, got;
    logic [P4_W-1:0]   p4_pin_in, p4_pin_out, p4_pin_oe;
    logic [P4_W-1:0]   p4_ext = 4'ha;
    logic [P5_W-1:0]   p5_pin_in, p5_pin_out, p5_pin_oe, p5_pullup_en;
    logic [P5_W-1:0]   p5_ext = 8'h3c;
    logic              ser_txd = 1'h0, ser_sck_out = 1'h0;
    logic              ser_rxd, ser_sck_in, ext_irq_zero_n;
    int                n_errors = 0, n_tests = 0, cyc = 0;
    int                d, l, f, e;

    port45_io DUT (.clock, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .p4_pin_in, .p4_pin_out, .p4_pin_oe, .p5_pin_in, .p5_pin_out,
        .p5_pin_oe, .p5_pullup_en, .ser_txd, .ser_sck_out, .ser_rxd, .ser_sck_in,
        .ext_irq_zero_n);
    pin_model partner (.p4_out(p4_pin_out), .p4_oe(p4_pin_oe), .p4_ext, .p4_lvl(p4_pin_in),
        .p5_out(p5_pin_out), .p5_oe(p5_pin_oe), .p5_pu(p5_pullup_en), .p5_ext,
        .p5_lvl(p5_pin_in));

    always #20 clock = ~clock;
    // whole run needs well under two thousand cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            conclude();
        end
    end

    task conclude();
        $display("mismatches %0d of %0d checks", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task chk(input logic [31:0] exp, input logic [31:0] act);
        n_tests++;
        if (act !== exp) begin
            n_errors++;
            $display("Error at %0t expected %h got %h", $time, exp, act);
        end
    endtask

    // settle past the edge so flop outputs are read after they land
    task w(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task wr(input logic [15:0] i, input logic [7:0] v);
        @(posedge clock);
        awaddr <= {i, 2'h0};
        wdata <= {24'h0, v};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
    endtask

    // response code lands in bits 31:30 so one compare covers both
    task rc(input logic [15:0] i, input logic [31:0] exp);
        @(posedge clock);
        araddr <= {i, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        got = rdata | {rresp, 30'h0};
        rready <= 1'h0;
        chk(exp, got);
    endtask

    initial begin
        void'($urandom(7));
        repeat (8) @(posedge clock);
        resetn <= 1'h1;
        w(6);
        rc(IDX_P5_FUNC, 32'h0);
        rc(IDX_P5_PULLUP, 32'h0);
        rc(IDX_P5_DIR, 32'hff);
        rc(IDX_P5_LATCH, {24'h0, p5_ext});
        chk(32'h0, 32'(p5_pin_oe));
        chk(32'h0, 32'(p5_pin_out));
        rc(16'h0, 32'h80000000);
        $display("test reset finished");
        for (int k = 0; k < 8; k++) begin
            d = $urandom & 32'hff;
            l = $urandom & 32'hff;
            e = $urandom & 32'hff;
            f = $urandom & 32'hff;
            wr(IDX_P5_DIR, d[7:0]);
            wr(IDX_P5_LATCH, l[7:0]);
            p5_ext <= e[7:0];
            w(6);
            rc(IDX_P5_LATCH, (l & d | e & ~d) & 32'hff);
            rc(IDX_P5_DIR, 32'hff);
            chk(d, 32'(p5_pin_oe));
            chk(l & d, 32'(p5_pin_out & d[7:0]));
            wr(IDX_P5_FUNC, f[7:0]);
            w(2);
            chk(d & ~f & 32'hff, 32'(p5_pin_oe));
            wr(IDX_P5_FUNC, 8'h0);
            wr(IDX_P5_PULLUP, f[7:0]);
            w(6);
            chk(~d & f & 32'hff, 32'(p5_pullup_en));
            rc(IDX_P5_PULLUP, f & 32'hff);
            rc(IDX_P5_LATCH, (l & d | (e | f) & ~d) & 32'hff);
            wr(IDX_P5_PULLUP, 8'h0);
        end
        wr(IDX_LCD_SEL, 8'h08);
        w(2);
        chk(d & 32'h0f, 32'(p5_pin_oe));
        wr(IDX_LCD_SEL, 8'h09);
        w(2);
        chk(32'h0, 32'(p5_pin_oe));
        $display("test port5 finished");
        wr(IDX_P4_DIR, 8'h07);
        wr(IDX_SER_CTRL, 8'h27);
        ser_txd <= 1'h1;
        w(6);
        chk(32'h9, {p4_pin_oe, p4_pin_out[2]});
        chk(32'h5, {ser_rxd, ser_sck_in, ext_irq_zero_n});
        ser_txd <= 1'h0;
        p4_ext <= 4'h5;
        w(6);
        chk(32'h2, {p4_pin_out[2], ser_rxd, ser_sck_in, ext_irq_zero_n});
        ser_sck_out <= 1'h1;
        wr(IDX_SER_CTRL, 8'h08);
        w(2);
        chk(32'h1f, {p4_pin_oe, p4_pin_out[0], ext_irq_zero_n});
        ser_sck_out <= 1'h0;
        wr(IDX_SER_CTRL, 8'h10);
        w(2);
        chk(32'h1d, {p4_pin_oe, p4_pin_out[0], ext_irq_zero_n});
        wr(IDX_SER_CTRL, 8'h00);
        w(2);
        chk(32'h7, 32'(p4_pin_oe));
        $display("test port4 finished");
        wr(IDX_PWR_MODE, 8'h02);
        wr(IDX_P4_DIR, 8'h00);
        w(2);
        chk(32'h7, 32'(p4_pin_oe));
        wr(IDX_PWR_MODE, 8'h03);
        wr(IDX_P4_DIR, 8'h02);
        w(2);
        chk(32'h7, 32'(p4_pin_oe));
        wr(IDX_PWR_MODE, 8'h04);
        w(2);
        chk(32'h7, 32'(p4_pin_oe));
        wr(IDX_PWR_MODE, 8'h05);
        w(2);
        chk(32'h0, 32'(p4_pin_oe));
        wr(IDX_PWR_MODE, 8'h01);
        w(2);
        chk(32'h2, 32'(p4_pin_oe));
        wr(IDX_PWR_MODE, 8'h00);
        w(2);
        chk(32'h2, 32'(p4_pin_oe));
        $display("test power finished");
        conclude();
    end
endmodule
